// >>> hdl/wdt_pkg.sv
package wdt_pkg;
   localparam logic [3:0] WDT_ADR_CTRL = 4'h0;
   localparam logic [3:0] WDT_ADR_CLOCK_CONTROL = 4'h4;
   localparam logic [3:0] WDT_ADR_TA = 4'h8;
   localparam logic [3:0] WDT_ADR_IRQ_STAT = 4'hC;
   localparam logic [3:0] WDT_ADR_IRQ_MASK = 4'h0;
   localparam int WDT_BIT_RESTART = 0;
   localparam int WDT_BIT_RST_EN = 1;
   localparam int WDT_BIT_CAUSE = 2;
   localparam int WDT_BIT_TOUT = 3;
   localparam int WDT_BIT_INT_EN = 4;
   localparam int WDT_BIT_SEL_LO = 6;
   localparam int WDT_BIT_SEL_HI = 7;
   localparam int WDT_TAP0 = 17;
   localparam int WDT_TAP1 = 20;
   localparam int WDT_TAP2 = 23;
   localparam int WDT_TAP3 = 26;
   localparam int WDT_CNT_W = 27;
   localparam int WDT_GRACE = 512;
   localparam logic [9:0] WDT_GRACE_LAST = 10'h1FF;
   localparam logic [7:0] WDT_TA_KEY1 = 8'hAA;
   localparam logic [7:0] WDT_TA_KEY2 = 8'h55;
   localparam logic [2:0] WDT_TA_WIN = 3'h3;
   localparam logic [7:0] WDT_CTRL_RST = 8'h00;
   localparam logic [1:0] WDT_SEL_RST = 2'h0;
   localparam logic [1:0] WDT_IRQ_RST = 2'h0;
   typedef enum logic [1:0] {
      WDT_TA_IDLE = 2'b00,
      WDT_TA_HALF = 2'b01,
      WDT_TA_OPEN = 2'b10
   } wdt_ta_t;
endpackage : wdt_pkg

// >>> hdl/wdt_top.sv
`timescale 1ns/1ps
module wdt_top
   import wdt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pwr_fail_rst_i,
   input wire logic global_int_en_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wdog_int_o,
   output logic wdog_sys_rst_o,
   output logic irq_o
);

   // bus decode
   logic req;
   logic rd;
   logic wr;
   logic [7:0] wbyte;
   logic hit_ctrl;
   logic hit_clock_control;
   logic hit_ta;
   logic hit_stat;
   logic wr_ctrl;
   logic wr_clock_control;
   logic wr_ta;
   logic wr_stat;
   logic wr_mask;

   // divider chain and grace window
   logic [WDT_CNT_W-1:0] cnt;
   logic [WDT_CNT_W-1:0] next_cnt;
   logic tap_hit;
   logic grace_run;
   logic next_grace_run;
   logic [9:0] grace_cnt;
   logic [9:0] next_grace_cnt;
   logic grace_end;
   logic rst_fire;
   logic restart;

   // timed access
   wdt_ta_t ta_st;
   wdt_ta_t next_ta_st;
   logic [2:0] ta_cnt;
   logic [2:0] next_ta_cnt;
   logic ta_ok;
   logic key1_wr;
   logic key2_wr;

   // register state
   logic [1:0] wdog_interval_sel;
   logic wdog_reset_enable;
   logic wdog_timeout_flag;
   logic wdog_reset_cause_flag;
   logic next_cause;
   logic wdog_int_en;
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] irq_clr;

   // output next values
   logic [31:0] next_rdata;
   logic next_int;
   logic next_sys_rst;
   logic next_ack;

   // a request is taken once; ack in flight masks the repeat
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd = req && !wb_we_i;
   // every write needs byte lane 0; it carries every control byte but the mask
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   assign hit_ctrl = (wb_adr_i == WDT_ADR_CTRL);
   assign hit_clock_control = (wb_adr_i == WDT_ADR_CLOCK_CONTROL);
   assign hit_ta = (wb_adr_i == WDT_ADR_TA);
   assign hit_stat = (wb_adr_i == WDT_ADR_IRQ_STAT);

   assign wr_ctrl = wr && hit_ctrl;
   assign wr_clock_control = wr && hit_clock_control;
   assign wr_ta = wr && hit_ta;
   assign wr_stat = wr && hit_stat;
   // mask shares the control word, lane 1
   assign wr_mask = wr && (wb_adr_i == WDT_ADR_IRQ_MASK) && wb_sel_i[1];

   assign key1_wr = wr_ta && (wbyte == WDT_TA_KEY1);
   assign key2_wr = wr_ta && (wbyte == WDT_TA_KEY2);
   assign ta_ok = (ta_st == WDT_TA_OPEN);

   assign restart = wr_ctrl && ta_ok && wbyte[WDT_BIT_RESTART];
   assign grace_end = grace_run && (grace_cnt == WDT_GRACE_LAST);
   // reset enable gates only the reset path; the grace count runs anyway
   assign rst_fire = grace_end && wdog_reset_enable;

   // select one divider tap; longer codes use longer taps
   always_comb begin
      tap_hit = 1'b0;
      case (wdog_interval_sel)
         2'b00: begin
            tap_hit = &cnt[WDT_TAP0-1:0];
         end
         2'b01: begin
            tap_hit = &cnt[WDT_TAP1-1:0];
         end
         2'b10: begin
            tap_hit = &cnt[WDT_TAP2-1:0];
         end
         2'b11: begin
            tap_hit = &cnt[WDT_TAP3-1:0];
         end
         default: begin
            tap_hit = 1'b0;
         end
      endcase
   end

   // the counter never stops; only restart and rst_i clear it
   always_comb begin
      if (restart) begin
         next_cnt = '0;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // grace window opens at the tap and lasts 512 clocks
   always_comb begin
      next_grace_run = grace_run;
      next_grace_cnt = grace_cnt;
      if (restart || grace_end) begin
         next_grace_run = 1'b0;
         next_grace_cnt = '0;
      end else if (tap_hit && !grace_run) begin
         next_grace_run = 1'b1;
         next_grace_cnt = '0;
      end else if (grace_run) begin
         next_grace_cnt = grace_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grace_run <= 1'b0;
         grace_cnt <= '0;
      end else begin
         grace_run <= next_grace_run;
         grace_cnt <= next_grace_cnt;
      end
   end

   // timed access: key1 then key2 to the unlock register, open for a few cycles
   always_comb begin
      next_ta_st = ta_st;
      next_ta_cnt = ta_cnt;
      case (ta_st)
         WDT_TA_IDLE: begin
            if (key1_wr) begin
               next_ta_st = WDT_TA_HALF;
               next_ta_cnt = '0;
            end
         end
         WDT_TA_HALF: begin
            next_ta_cnt = ta_cnt + 1'b1;
            if (key2_wr) begin
               next_ta_st = WDT_TA_OPEN;
               next_ta_cnt = '0;
            end else if (ta_cnt == WDT_TA_WIN) begin
               next_ta_st = WDT_TA_IDLE;
            end
         end
         WDT_TA_OPEN: begin
            next_ta_cnt = ta_cnt + 1'b1;
            // one protected write per unlock, then it closes
            if (wr_ctrl || ta_cnt == WDT_TA_WIN) begin
               next_ta_st = WDT_TA_IDLE;
            end
         end
         default: begin
            next_ta_st = WDT_TA_IDLE;
            next_ta_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ta_st <= WDT_TA_IDLE;
         ta_cnt <= '0;
      end else begin
         ta_st <= next_ta_st;
         ta_cnt <= next_ta_cnt;
      end
   end

   // reset enable is a protected bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_reset_enable <= WDT_CTRL_RST[WDT_BIT_RST_EN];
      end else if (wr_ctrl && ta_ok) begin
         wdog_reset_enable <= wbyte[WDT_BIT_RST_EN];
      end
   end

   // time-out flag: a tap hit beats a clear written in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_timeout_flag <= WDT_CTRL_RST[WDT_BIT_TOUT];
      end else if (tap_hit) begin
         wdog_timeout_flag <= 1'b1;
      end else if (wr_ctrl && ta_ok) begin
         wdog_timeout_flag <= wbyte[WDT_BIT_TOUT];
      end
   end

   // interrupt enable is not protected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_int_en <= WDT_CTRL_RST[WDT_BIT_INT_EN];
      end else if (wr_ctrl) begin
         wdog_int_en <= wbyte[WDT_BIT_INT_EN];
      end
   end

   // cause flag next value; a watchdog reset wins over a software clear
   always_comb begin
      next_cause = wdog_reset_cause_flag;
      if (rst_fire) begin
         next_cause = 1'b1;
      end else if (wr_ctrl && !wbyte[WDT_BIT_CAUSE]) begin
         next_cause = 1'b0;
      end
   end

   // cause flag survives the ordinary reset; only power-fail clears it by hardware
   always_ff @(posedge clk_i) begin
      if (pwr_fail_rst_i) begin
         wdog_reset_cause_flag <= 1'b0;
      end else begin
         wdog_reset_cause_flag <= next_cause;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_interval_sel <= WDT_SEL_RST;
      end else if (wr_clock_control) begin
         wdog_interval_sel <= {wbyte[WDT_BIT_SEL_HI], wbyte[WDT_BIT_SEL_LO]};
      end
   end

   // sticky status: bit0 time-out event, bit1 reset event; write one clears, set wins
   always_comb begin
      irq_clr = 2'b00;
      if (wr_stat) begin
         irq_clr = wbyte[1:0];
      end
      next_irq_stat = (irq_stat & ~irq_clr) | {rst_fire, tap_hit};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= WDT_IRQ_RST;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= WDT_IRQ_RST;
      end else if (wr_mask) begin
         irq_mask <= wb_dat_i[9:8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // interrupt and reset paths never gate each other
   always_comb begin
      next_int = wdog_timeout_flag && wdog_int_en && global_int_en_i;
      next_sys_rst = rst_fire;
      next_ack = req;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_int_o <= 1'b0;
      end else begin
         wdog_int_o <= next_int;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdog_sys_rst_o <= 1'b0;
      end else begin
         wdog_sys_rst_o <= next_sys_rst;
      end
   end

   // restart always reads back as zero: it only pulses
   always_comb begin
      next_rdata = '0;
      if (rd) begin
         case (wb_adr_i)
            WDT_ADR_CTRL: begin
               next_rdata[WDT_BIT_RESTART] = 1'b0;
               next_rdata[WDT_BIT_RST_EN] = wdog_reset_enable;
               next_rdata[WDT_BIT_CAUSE] = wdog_reset_cause_flag;
               next_rdata[WDT_BIT_TOUT] = wdog_timeout_flag;
               next_rdata[WDT_BIT_INT_EN] = wdog_int_en;
               next_rdata[9:8] = irq_mask;
            end
            WDT_ADR_CLOCK_CONTROL: begin
               next_rdata[WDT_BIT_SEL_HI] = wdog_interval_sel[1];
               next_rdata[WDT_BIT_SEL_LO] = wdog_interval_sel[0];
            end
            WDT_ADR_TA: begin
               next_rdata[0] = ta_ok;
            end
            WDT_ADR_IRQ_STAT: begin
               next_rdata[1:0] = irq_stat;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // single-wait slave: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= next_ack;
      end
   end

   // read data stands only in the ack cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else begin
         wb_dat_o <= next_rdata;
      end
   end
endmodule : wdt_top

// >>> tb/wdt_top_props.sv
`timescale 1ns/1ps
module wdt_top_props
   import wdt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic global_int_en_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wdog_int_o,
   input wire logic wdog_sys_rst_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_src: assert property (p_ack_src) else $error("ack without request");
   property p_rst_rd;
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == WDT_ADR_CTRL |=> !wb_dat_o[WDT_BIT_RESTART];
   endproperty
   a_rst_rd: assert property (p_rst_rd) else $error("restart bit read as one");
   property p_int_gate; wdog_int_o |-> $past(global_int_en_i); endproperty
   a_int_gate: assert property (p_int_gate) else $error("interrupt without global enable");
   property p_int_off; !global_int_en_i |=> !wdog_int_o; endproperty
   a_int_off: assert property (p_int_off) else $error("interrupt not blocked");
   property p_sys_pulse; wdog_sys_rst_o |=> !wdog_sys_rst_o [*8]; endproperty
   a_sys_pulse: assert property (p_sys_pulse) else $error("reset pulse repeated");
   property p_quiet; $fell(rst_i) |-> !wdog_sys_rst_o && !wdog_int_o && !irq_o; endproperty
   a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule : wdt_top_props
bind wdt_top wdt_top_props u_props (.*);

// >>> tb/tb_watchdog_timer.sv
`timescale 1ns/1ps
module tb_watchdog_timer
   import wdt_pkg::*;
;
   logic clk_i = 0, rst_i = 1, pwr_fail_rst_i = 1, global_int_en_i = 1;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wdog_int_o, wdog_sys_rst_o, irq_o;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   int mismatches = 0, comparisons = 0, t, n;
   wdt_top u_dut (.*);
   always #5 clk_i = ~clk_i;
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : bus
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic tf, ie, cs, en);
      return {22'h00_0000, m, 3'h0, ie, tf, cs, en, 1'h0};
   endfunction : ctl
   initial begin
      // one time-out plus grace plus bus traffic fits well inside this span
      repeat (140000) @(posedge clk_i);
      mismatches++;
      print_verdict();
   end
   initial begin
      void'($urandom(74612));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      pwr_fail_rst_i <= 1'h0;
      bus(0, WDT_ADR_CTRL, 4'hF, 0); chk("ctrl", ctl(0, 0, 0, 0, 0), q);
      bus(0, 4'h1, 4'hF, 0); chk("unmapped", 0, q);
      bus(1, WDT_ADR_CTRL, 4'h1, 32'h0000_001B);
      bus(0, WDT_ADR_CTRL, 4'hF, 0); chk("locked", ctl(0, 0, 1, 0, 0), q);
      for (int i = 0; i < 4; i++) begin
         bus(1, WDT_ADR_CLOCK_CONTROL, 4'h1, {24'h00_0000, 2'(i), 6'($urandom)});
         bus(0, WDT_ADR_CLOCK_CONTROL, 4'hF, 0); chk("sel", {24'h00_0000, 2'(i), 6'h00}, q & 32'h0000_00C0);
      end
      bus(1, WDT_ADR_CLOCK_CONTROL, 4'h1, 0);
      bus(1, WDT_ADR_TA, 4'h1, 32'(WDT_TA_KEY1));
      bus(1, WDT_ADR_TA, 4'h1, 32'(WDT_TA_KEY2));
      bus(1, WDT_ADR_CTRL, 4'h3, 32'h0000_0313);
      global_int_en_i <= 1'h0;
      t = 0;
      while (irq_o !== 1'h1) begin
         @(negedge clk_i);
         t++;
      end
      chk("tout", 1, 32'(t >= (1 << WDT_TAP0) - 8 && t <= (1 << WDT_TAP0) + 2));
      chk("int_blocked", 0, 32'(wdog_int_o));
      global_int_en_i <= 1'h1;
      n = 0;
      while (wdog_sys_rst_o !== 1'h1) begin
         @(negedge clk_i);
         n++;
      end
      chk("grace", 1, 32'(n >= WDT_GRACE - 2 && n <= WDT_GRACE));
      chk("int", 1, 32'(wdog_int_o));
      bus(0, WDT_ADR_CTRL, 4'hF, 0); chk("cause", ctl(3, 1, 1, 1, 1), q);
      bus(0, WDT_ADR_IRQ_STAT, 4'hF, 0); chk("status", 32'h0000_0003, q);
      bus(1, WDT_ADR_IRQ_STAT, 4'h1, 32'h0000_0003);
      repeat (2) @(negedge clk_i);
      chk("irq", 0, 32'(irq_o));
      bus(1, WDT_ADR_CTRL, 4'h3, 32'h0000_0310);
      bus(0, WDT_ADR_CTRL, 4'hF, 0); chk("cleared", ctl(3, 1, 1, 0, 1), q);
      print_verdict();
   end
endmodule : tb_watchdog_timer
